// ### src/sarsq_pkg.sv
// Purpose: Shared constants and types for the converter sequencer control
// Assumes: 100 MHz system clock, converter clock derived by an enable
// Notes:   Timing figures kept in their own units, cycle counts derived
package sarsq_pkg;

    localparam int SARSQ_SYS_MHZ       = 100;
    localparam int SARSQ_CONV_MHZ_MAX  = 18;
    localparam int SARSQ_CONV_CLKS_MIN = 18;
    localparam int SARSQ_RATE_KSPS     = 1000;
    // Converter clock divider: round up so the rate stays at or below max
    localparam int SARSQ_DIV = (SARSQ_SYS_MHZ + SARSQ_CONV_MHZ_MAX - 1)
                               / SARSQ_CONV_MHZ_MAX;
    localparam int SARSQ_CH_N   = 8;
    localparam int SARSQ_RES_W  = 12;
    localparam int SARSQ_ST_W   = 8;
    localparam logic [SARSQ_ST_W-1:0] SARSQ_ST_RST = 8'h03;
    localparam logic [SARSQ_RES_W-1:0] SARSQ_LO_RST = 12'h000;
    localparam logic [SARSQ_RES_W-1:0] SARSQ_HI_RST = 12'hFFF;
    localparam int SARSQ_FIFO_DEPTH = 16;

    typedef enum logic [2:0] {
        SARSQ_IDLE   = 3'b000,
        SARSQ_SAMPLE = 3'b001,
        SARSQ_CONV   = 3'b010,
        SARSQ_STORE  = 3'b011,
        SARSQ_NEXT   = 3'b100
    } sarsq_state_t;

    typedef struct packed {
        logic [2:0]             chan;
        logic [SARSQ_RES_W-1:0] value;
        logic                   out_of_range;
    } sarsq_result_t;

endpackage : sarsq_pkg

// ### src/sarsq_fifo.sv
// Purpose: Parameterised result FIFO with valid/ready on both sides
// Assumes: Single clock, synchronous active-high reset
// Notes:   Full and empty are exact; no write when full, no read when empty
`timescale 1ns/1ps
module sarsq_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_in,    // System clock
    input  wire logic             rst_in,    // Synchronous reset
    input  wire logic             wr_valid_in, // Write request
    output logic                  wr_ready_out, // Space available
    input  wire logic [WIDTH-1:0] wr_data_in,  // Write data
    output logic                  rd_valid_out, // Data available
    input  wire logic             rd_ready_in,  // Read accept
    output logic      [WIDTH-1:0] rd_data_out   // Read data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wptr, rptr, next_wptr, next_rptr;
    logic [AW:0]      count, next_count;
    logic             do_wr, do_rd;

    assign wr_ready_out = (count != (AW+1)'(DEPTH));
    assign rd_valid_out = (count != '0);
    assign rd_data_out  = mem[rptr];
    assign do_wr = wr_valid_in && wr_ready_out;
    assign do_rd = rd_ready_in && rd_valid_out;

    always_comb begin
        next_wptr  = do_wr ? wptr + 1'b1 : wptr;
        next_rptr  = do_rd ? rptr + 1'b1 : rptr;
        next_count = count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wptr  <= '0;
            rptr  <= '0;
            count <= '0;
        end else begin
            wptr  <= next_wptr;
            rptr  <= next_rptr;
            count <= next_count;
        end
        if (do_wr) mem[wptr] <= wr_data_in;
    end

    property p_fifo_no_over;
        @(posedge clk_in) disable iff (rst_in)
        count <= (AW+1)'(DEPTH);
    endproperty
    a_fifo_no_over: assert property (p_fifo_no_over)
        else $error("fifo count over depth");
endmodule : sarsq_fifo

// ### src/sarsq_top.sv
// Purpose: Sequencer control for a 12-bit successive-approximation converter
// Assumes: Analog core returns a result after the conversion clocks
// Notes:   Converter clock is an enable pulse; halted in deep low power
// How it works
// - Converter clock at most 18 MHz, 18 clocks
// - No dead time between sequenced channels
// - Acquisition window length is programmable
// - Eight-input sequencer scans selected channels autonomously
// - Channel from state machine or firmware
// - Each channel result held in own buffer
// - Per-channel sample time applied during acquisition
// - Low/high limits compared, out-of-range interrupt
// - Range flag raised when the result is accepted by the FIFO
// - Converter inactive in deepest low-power state
// - Converter clock stopped until chip wakes
`timescale 1ns/1ps
module sarsq_top
    import sarsq_pkg::*;
#(
    parameter int CH_N  = SARSQ_CH_N,
    parameter int RES_W = SARSQ_RES_W
) (
    input  wire logic                   clk_in,         // 100 MHz clock
    input  wire logic                   rst_in,         // Sync reset
    input  wire logic                   enable_in,      // Block enable
    input  wire logic                   deep_sleep_in,  // Deepest low power
    input  wire logic                   start_in,       // Start scan pulse
    input  wire logic                   continuous_in,  // Repeat scans
    input  wire logic                   fw_mode_in,     // Firmware selects
    input  wire logic [2:0]             fw_chan_in,     // Firmware channel
    input  wire logic [CH_N-1:0]        chan_en_in,     // Enabled channels
    input  wire logic [CH_N*SARSQ_ST_W-1:0] samp_time_in, // Per-chan clocks
    input  wire logic [RES_W-1:0]       lim_lo_in,      // Low limit
    input  wire logic [RES_W-1:0]       lim_hi_in,      // High limit
    input  wire logic                   range_clr_in,   // Clear range flag
    input  wire logic                   eos_clr_in,     // Clear end of scan
    input  wire logic [RES_W-1:0]       core_result_in, // Analog core result
    input  wire logic [2:0]             rd_chan_in,     // Buffer read index
    output logic      [RES_W-1:0]       rd_data_out,    // Buffer read data
    output logic      [2:0]             mux_sel_out,    // Analog mux select
    output logic                        sample_out,     // Track/hold: track
    output logic                        conv_clk_en_out, // Converter clock
    output logic                        busy_out,       // Scan in progress
    output logic                        eos_out,        // End of scan, sticky
    output logic                        range_irq_out,  // Out of range
    output logic      [2:0]             range_chan_out, // Offending channel
    output logic                        res_valid_out,  // Stream valid
    input  wire logic                   res_ready_in,   // Stream ready
    output sarsq_result_t               res_data_out,   // Stream data
    output logic                        stall_out       // FIFO full stall
);
    localparam logic [4:0] CONV_LAST = 5'(SARSQ_CONV_CLKS_MIN - 1);
    localparam logic [3:0] DIV_LAST  = 4'(SARSQ_DIV - 1);
    localparam int         CONV_CYC  = SARSQ_CONV_CLKS_MIN * SARSQ_DIV;

    function automatic logic in_range_f(
        input logic [RES_W-1:0] v, lo, hi);
        in_range_f = (v >= lo && v <= hi) ? 1'b1 : 1'b0;
    endfunction : in_range_f

    // Next enabled channel strictly above c; 4'h8 when none
    function automatic logic [3:0] next_ch_f(input logic [CH_N-1:0] en,
                                              input logic [3:0] c);
        next_ch_f = 4'h8;
        for (int i = CH_N - 1; i >= 0; i--) begin
            if (en[i] && 4'(i) > c) next_ch_f = 4'(i);
        end
    endfunction : next_ch_f

    // Lowest enabled channel; 0 when none
    function automatic logic [2:0] first_ch_f(input logic [CH_N-1:0] en);
        first_ch_f = 3'h0;
        for (int i = CH_N - 1; i >= 0; i--) begin
            if (en[i]) first_ch_f = 3'(i);
        end
    endfunction : first_ch_f

    sarsq_state_t     state, next_state;
    logic [3:0]       div, next_div;
    logic             ck_en;
    logic [2:0]       chan, next_chan;
    logic [7:0]       tcnt, next_tcnt;
    logic [4:0]       ccnt, next_ccnt;
    logic [RES_W-1:0] buf_mem [CH_N];
    logic             eos, next_eos, rirq, next_rirq;
    logic [2:0]       rchan, next_rchan;
    logic             run, next_run;
    logic             fifo_rdy;
    logic             bad;
    logic [3:0]       nxt;
    logic [SARSQ_ST_W-1:0] st_sel;
    logic             active;
    sarsq_result_t    wr_res;
    logic             samp_entry;
    logic [11:0]      win_cyc, next_win_cyc;

    assign active = enable_in && !deep_sleep_in;
    // Converter clock enable: 100/6 MHz, under the 18 MHz ceiling
    // Restarted on entry to acquisition so the window is whole clocks
    assign samp_entry = (next_state == SARSQ_SAMPLE)
                     && (state != SARSQ_SAMPLE);
    always_comb begin
        next_div = (!active || samp_entry || div == DIV_LAST) ? 4'h0 :
                   div + 4'h1;
    end
    assign ck_en = active && (div == DIV_LAST);

    assign st_sel = samp_time_in[chan*SARSQ_ST_W +: SARSQ_ST_W];
    assign bad = !in_range_f(core_result_in, lim_lo_in, lim_hi_in);
    assign nxt = next_ch_f(chan_en_in, {1'b0, chan});

    always_comb begin
        next_state = state;
        next_chan  = chan;
        next_tcnt  = tcnt;
        next_ccnt  = ccnt;
        next_run   = run;
        next_eos   = eos;
        next_rirq  = rirq;
        next_rchan = rchan;
        if (eos_clr_in) next_eos = 1'b0;
        if (range_clr_in) next_rirq = 1'b0;
        case (state)
            SARSQ_IDLE: begin
                if (active && (start_in || run) && chan_en_in != '0) begin
                    next_run   = continuous_in;
                    next_chan  = fw_mode_in ? fw_chan_in :
                                 first_ch_f(chan_en_in);
                    next_tcnt  = 8'h00;
                    next_state = SARSQ_SAMPLE;
                end
            end
            SARSQ_SAMPLE: begin
                if (ck_en) begin
                    if (tcnt >= st_sel) begin
                        next_ccnt  = 5'h00;
                        next_state = SARSQ_CONV;
                    end else begin
                        next_tcnt = tcnt + 8'h01;
                    end
                end
            end
            SARSQ_CONV: begin
                if (ck_en) begin
                    if (ccnt == CONV_LAST) next_state = SARSQ_STORE;
                    else next_ccnt = ccnt + 5'h01;
                end
            end
            SARSQ_STORE: begin
                if (fifo_rdy) begin
                    if (bad) begin
                        next_rirq  = 1'b1;
                        next_rchan = chan;
                    end
                    next_state = SARSQ_NEXT;
                end
            end
            default: begin
                // Step straight to next channel's sample, no idle gap
                next_tcnt = 8'h00;
                if (!fw_mode_in && nxt != 4'h8) begin
                    next_chan  = nxt[2:0];
                    next_state = SARSQ_SAMPLE;
                end else begin
                    next_eos   = 1'b1;
                    // Rescan only while the continuous level still stands
                    next_run   = run && continuous_in;
                    if (run && continuous_in && active) begin
                        next_chan  = fw_mode_in ? fw_chan_in :
                            first_ch_f(chan_en_in);
                        next_state = SARSQ_SAMPLE;
                    end else begin
                        next_state = SARSQ_IDLE;
                    end
                end
            end
        endcase
        if (!active) begin
            next_state = SARSQ_IDLE;
            next_run   = 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state <= SARSQ_IDLE;
            div   <= 4'h0;
            chan  <= 3'h0;
            tcnt  <= 8'h00;
            ccnt  <= 5'h00;
            run   <= 1'b0;
            eos   <= 1'b0;
            rirq  <= 1'b0;
            rchan <= 3'h0;
        end else begin
            state <= next_state;
            div   <= next_div;
            chan  <= next_chan;
            tcnt  <= next_tcnt;
            ccnt  <= next_ccnt;
            run   <= next_run;
            eos   <= next_eos;
            rirq  <= next_rirq;
            rchan <= next_rchan;
        end
        if (state == SARSQ_STORE && fifo_rdy)
            buf_mem[chan] <= core_result_in;
    end

    // Cycles spent in the present state, for the timing checks
    always_comb begin
        if (next_state != state) next_win_cyc = 12'h000;
        else if (win_cyc == 12'hFFF) next_win_cyc = win_cyc;
        else next_win_cyc = win_cyc + 12'h001;
    end
    always_ff @(posedge clk_in) begin
        if (rst_in) win_cyc <= 12'h000;
        else win_cyc <= next_win_cyc;
    end

    assign wr_res = '{chan: chan, value: core_result_in, out_of_range: bad};
    sarsq_fifo #(
        .WIDTH ($bits(sarsq_result_t)),
        .DEPTH (SARSQ_FIFO_DEPTH)
    ) u_fifo (
        .clk_in       (clk_in),
        .rst_in       (rst_in),
        .wr_valid_in  (state == SARSQ_STORE),
        .wr_ready_out (fifo_rdy),
        .wr_data_in   (wr_res),
        .rd_valid_out (res_valid_out),
        .rd_ready_in  (res_ready_in),
        .rd_data_out  (res_data_out)
    );

    assign rd_data_out     = buf_mem[rd_chan_in];
    assign mux_sel_out     = chan;
    assign sample_out      = (state == SARSQ_SAMPLE);
    assign conv_clk_en_out = ck_en && (state == SARSQ_CONV);
    assign busy_out        = (state != SARSQ_IDLE);
    assign eos_out         = eos;
    assign range_irq_out   = rirq;
    assign range_chan_out  = rchan;
    assign stall_out       = (state == SARSQ_STORE) && !fifo_rdy;

    sequence s_conv_done;
        state == SARSQ_CONV && next_state == SARSQ_STORE;
    endsequence
    sequence s_samp_done;
        state == SARSQ_SAMPLE && next_state == SARSQ_CONV;
    endsequence
    property p_conv_len;
        @(posedge clk_in) disable iff (rst_in)
        s_conv_done |-> win_cyc >= 12'(CONV_CYC - 1);
    endproperty
    a_conv_len: assert property (p_conv_len)
        else $error("conversion shorter than minimum");
    property p_samp_len;
        @(posedge clk_in) disable iff (rst_in)
        s_samp_done |-> win_cyc + 12'h001 ==
            12'(SARSQ_DIV) * ({4'h0, st_sel} + 12'h001);
    endproperty
    a_samp_len: assert property (p_samp_len)
        else $error("acquisition window differs from setting");
    property p_sleep_stop;
        @(posedge clk_in) disable iff (rst_in)
        deep_sleep_in |-> !ck_en ##1 div == 4'h0;
    endproperty
    a_sleep_stop: assert property (p_sleep_stop)
        else $error("converter clock runs in deep sleep");
    property p_sleep_idle;
        @(posedge clk_in) disable iff (rst_in)
        deep_sleep_in |=> state == SARSQ_IDLE;
    endproperty
    a_sleep_idle: assert property (p_sleep_idle)
        else $error("sequencer active in deep sleep");
    property p_range_set;
        @(posedge clk_in) disable iff (rst_in)
        (state == SARSQ_STORE && fifo_rdy && bad)
            |=> rirq && rchan == $past(chan);
    endproperty
    a_range_set: assert property (p_range_set)
        else $error("range flag not raised at conversion end");
    property p_range_hold;
        @(posedge clk_in) disable iff (rst_in)
        rirq && !range_clr_in |=> rirq;
    endproperty
    a_range_hold: assert property (p_range_hold)
        else $error("range flag dropped without clear");
    property p_no_gap;
        @(posedge clk_in) disable iff (rst_in)
        (state == SARSQ_NEXT && !fw_mode_in && nxt != 4'h8 && active)
            |=> state == SARSQ_SAMPLE;
    endproperty
    a_no_gap: assert property (p_no_gap)
        else $error("dead time between channels");
    property p_ascend;
        @(posedge clk_in) disable iff (rst_in)
        (state == SARSQ_NEXT && !fw_mode_in && nxt != 4'h8 && active)
            |=> chan > $past(chan);
    endproperty
    a_ascend: assert property (p_ascend)
        else $error("channels not visited in ascending order");
    property p_buf;
        @(posedge clk_in) disable iff (rst_in)
        (state == SARSQ_STORE && fifo_rdy)
            |=> buf_mem[$past(chan)] == $past(core_result_in);
    endproperty
    a_buf: assert property (p_buf)
        else $error("result buffer not updated");
endmodule : sarsq_top

// ### tb/sarsq_analog_model.sv
// Purpose: Analog input pins as seen through the channel multiplexer
// Assumes: Core result reflects the channel held at end of acquisition
// Notes:   Value is meaningless while tracking, shown inverted then
`timescale 1ns/1ps
module sarsq_analog_model (
    input  wire logic        clk_in,     // System clock
    input  wire logic [2:0]  mux_sel_in, // Selected channel
    input  wire logic        sample_in,  // Acquisition window
    output logic      [11:0] result_out  // Converted value
);
    logic [11:0] held;

    initial held = 12'h0000;
    always @(posedge clk_in) begin
        if (sample_in) begin
            held <= {mux_sel_in, 9'h050};
        end
    end
    assign result_out = sample_in ? ~held : held;
endmodule : sarsq_analog_model

// ### tb/sarsq_top_tb.sv
// Purpose: Self-checking bench for the converter sequencer control
// Assumes: Channel c converts to {c, 9'h050}; inputs move 1 ns past edge
// Notes:   Monitor records acquisition lengths and converter clock counts
`timescale 1ns/1ps
module sarsq_top_tb
    import sarsq_pkg::*;
();
    logic          clk_in, rst_in, enable_in, deep_sleep_in, start_in;
    logic          continuous_in, fw_mode_in, range_clr_in, eos_clr_in;
    logic          res_ready_in, sample_out, conv_clk_en_out, busy_out;
    logic          eos_out, range_irq_out, res_valid_out, stall_out;
    logic [2:0]    fw_chan_in, rd_chan_in, mux_sel_out, range_chan_out;
    logic [7:0]    chan_en_in;
    logic [63:0]   samp_time_in;
    logic [11:0]   lim_lo_in, lim_hi_in, core_result, rd_data_out;
    sarsq_result_t res_data_out;
    int            fails = 0, compares = 0, cyc = 0, scnt = 0, ccnt = 0;
    int            gap = 100, i, n;
    int            sq[$], cq[$];

    sarsq_top u_dut (.clk_in(clk_in), .rst_in(rst_in),
        .enable_in(enable_in), .deep_sleep_in(deep_sleep_in),
        .start_in(start_in), .continuous_in(continuous_in),
        .fw_mode_in(fw_mode_in), .fw_chan_in(fw_chan_in),
        .chan_en_in(chan_en_in), .samp_time_in(samp_time_in),
        .lim_lo_in(lim_lo_in), .lim_hi_in(lim_hi_in),
        .range_clr_in(range_clr_in), .eos_clr_in(eos_clr_in),
        .core_result_in(core_result), .rd_chan_in(rd_chan_in),
        .rd_data_out(rd_data_out), .mux_sel_out(mux_sel_out),
        .sample_out(sample_out), .conv_clk_en_out(conv_clk_en_out),
        .busy_out(busy_out), .eos_out(eos_out),
        .range_irq_out(range_irq_out), .range_chan_out(range_chan_out),
        .res_valid_out(res_valid_out), .res_ready_in(res_ready_in),
        .res_data_out(res_data_out), .stall_out(stall_out));

    sarsq_analog_model u_pins (.clk_in(clk_in), .mux_sel_in(mux_sel_out),
        .sample_in(sample_out), .result_out(core_result));

    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        compares++;
        if (exp !== got) begin
            fails++;
            $display("unexpected %s: expected %0h, seen %0h", name, exp, got);
        end
    endtask : chk

    task automatic tick(input int k);
        repeat (k) @(posedge clk_in);
        #1;
    endtask : tick

    task automatic start_scan();
        start_in = 1'b1;
        tick(1);
        start_in = 1'b0;
    endtask : start_scan

    task automatic wait_idle();
        int k;
        for (k = 0; k < 3000 && busy_out !== 1'b0; k++) tick(1);
        chk("busy", 0, busy_out);
        tick(1);
    endtask : wait_idle

    task automatic pop(input logic [2:0] c);
        logic [11:0] v;
        int          k;
        v = {c, 9'h050};
        k = 0;
        do begin
            tick(1);
            k++;
        end while (k < 3000 && res_valid_out !== 1'b1);
        chk("chan", c, res_data_out.chan);
        chk("value", v, res_data_out.value);
        chk("range bit", v < lim_lo_in || v > lim_hi_in,
            res_data_out.out_of_range);
        res_ready_in = 1'b1;
        tick(1);
        res_ready_in = 1'b0;
    endtask : pop

    task automatic results();
        if (fails == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    // Acquisition length and converter clock census
    always @(posedge clk_in) begin
        cyc++;
        if ((sample_out || !busy_out) && ccnt > 0) begin
            cq.push_back(ccnt);
            ccnt = 0;
        end
        if (sample_out) scnt++;
        else if (scnt > 0) begin
            sq.push_back(scnt);
            scnt = 0;
        end
        if (conv_clk_en_out) begin
            if (gap < SARSQ_DIV) chk("clock gap", SARSQ_DIV, gap);
            gap = 1;
            if (busy_out && !sample_out) ccnt++;
        end else gap++;
        if (cyc == 20000) begin
            fails++;
            results();
        end
    end

    initial begin
        {rst_in, enable_in} = 2'b11;
        {deep_sleep_in, start_in, continuous_in, fw_mode_in} = 4'h0;
        {range_clr_in, eos_clr_in, res_ready_in} = 3'b000;
        {fw_chan_in, rd_chan_in} = 6'h00;
        chan_en_in = 8'h36;
        for (i = 0; i < 8; i++) samp_time_in[i*8 +: 8] = i[7:0];
        lim_lo_in = 12'h0300;
        lim_hi_in = 12'h0A00;
        tick(3);
        rst_in = 1'b0;
        chk("reset outs", 0, {busy_out, eos_out, range_irq_out,
            res_valid_out, stall_out, sample_out, mux_sel_out});
        // Scan of channels 1,2,4,5; second start mid-scan is ignored
        start_scan();
        tick(50);
        start_scan();
        for (i = 0; i < 8; i++) begin
            if (chan_en_in[i]) begin
                pop(i[2:0]);
                if (i == 1) chk("early flag", 7'h61,
                    {busy_out, range_irq_out, 2'b00, range_chan_out});
                chk("sample len", (i + 1) * SARSQ_DIV, sq.pop_front());
            end
        end
        wait_idle();
        chk("no extra", 0, res_valid_out);
        chk("eos", 1, eos_out);
        chk("irq sticky", 1, range_irq_out);
        chk("conv count", 4, cq.size());
        while (cq.size() > 0) chk("conv clks", SARSQ_CONV_CLKS_MIN,
            cq.pop_front());
        for (i = 0; i < 8; i++) begin
            if (chan_en_in[i]) begin
                rd_chan_in = i[2:0];
                tick(1);
                chk("buffer", {i[2:0], 9'h050}, rd_data_out);
            end
        end
        range_clr_in = 1'b1;
        eos_clr_in = 1'b1;
        tick(1);
        {range_clr_in, eos_clr_in} = 2'b00;
        tick(1);
        chk("cleared", 0, {eos_out, range_irq_out});
        // Firmware-selected single conversion
        fw_mode_in = 1'b1;
        fw_chan_in = 3'h6;
        start_scan();
        pop(3'h6);
        wait_idle();
        chk("fw flag", 4'hE, {range_irq_out, range_chan_out});
        chk("fw sample len", 7 * SARSQ_DIV, sq.pop_back());
        fw_mode_in = 1'b0;
        // Refused in deep sleep, and sleep aborts a conversion
        deep_sleep_in = 1'b1;
        start_scan();
        tick(3);
        chk("sleep start", 0, busy_out);
        deep_sleep_in = 1'b0;
        start_scan();
        tick(40);
        chk("converting", 1, busy_out);
        deep_sleep_in = 1'b1;
        tick(2);
        n = 0;
        repeat (30) begin
            tick(1);
            n += conv_clk_en_out;
        end
        chk("sleep clocks", 0, n);
        chk("sleep abort", 0, {busy_out, res_valid_out});
        deep_sleep_in = 1'b0;
        // Fill the FIFO until it stalls, then drain it
        sq.delete();
        cq.delete();
        chan_en_in = 8'hFF;
        continuous_in = 1'b1;
        start_scan();
        for (i = 0; i < 6000 && stall_out !== 1'b1; i++) tick(1);
        chk("stall", 1, stall_out);
        continuous_in = 1'b0;
        for (i = 0; i < 16; i++) pop(i[2:0]);
        res_ready_in = 1'b1;
        for (i = 0; i < 3000 && (busy_out || res_valid_out); i++) tick(1);
        res_ready_in = 1'b0;
        chk("drained", 0, {stall_out, res_valid_out, busy_out});
        results();
    end
endmodule : sarsq_top_tb
